// File: line_supervisor_pkg.sv
package line_supervisor_pkg;
    localparam int CLOCK_HZ = 20000000;
    // time figures in their own units
    localparam int SAG_BLANK_US       = 50000;
    localparam int UNDERVOLT_BLANK_MS = 50;
    localparam int LINE_FILTER_US     = 300;
    localparam int LOW_LINE_MS        = 25;
    localparam int LOCKOUT_MS         = 500;
    localparam int REMOVAL_MS         = 32;
    localparam int RESTART_DELAY_MS   = 515;
    // derived cycle counts
    localparam int SAG_BLANK_CYC      = SAG_BLANK_US * (CLOCK_HZ / 1000000);
    localparam int UNDERVOLT_BLANK_CYC = UNDERVOLT_BLANK_MS * (CLOCK_HZ / 1000);
    localparam int LINE_FILTER_CYC    = LINE_FILTER_US * (CLOCK_HZ / 1000000);
    localparam int LOW_LINE_CYC       = LOW_LINE_MS * (CLOCK_HZ / 1000);
    localparam int LOCKOUT_CYC        = LOCKOUT_MS * (CLOCK_HZ / 1000);
    localparam int REMOVAL_CYC        = REMOVAL_MS * (CLOCK_HZ / 1000);
    localparam int RESTART_DELAY_CYC  = RESTART_DELAY_MS * (CLOCK_HZ / 1000);
    localparam int TIMER_W            = 24;
    localparam int CONTROL_W          = 10;
    localparam int SENSE_W            = 10;
    localparam logic [CONTROL_W-1:0] CONTROL_ZERO = 10'h000;
    localparam logic [CONTROL_W-1:0] CONTROL_STEP = 10'h001;
    localparam logic [CONTROL_W-1:0] FOLDBACK_LEVEL = 10'h100;
    localparam logic [1:0] BANDWIDTH_SHIFT_HIGH = 2'h2;
    localparam logic [1:0] BANDWIDTH_SHIFT_LOW  = 2'h0;
    typedef enum logic [2:0] {ST_WAIT_SUPPLY, ST_RUN, ST_SOFT_STOP, ST_FAULT, ST_RESTART_WAIT, ST_DISCHARGE}
        run_state_t;
endpackage : line_supervisor_pkg

// File: hold_timer.sv
`timescale 1ns/10ps
`default_nettype none
// counts while cond_i holds, reports done once the count reaches limit_i
module hold_timer
#(
    parameter int WIDTH = 24
)
(
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    input  wire logic             cond_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  done_o
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             done_next;

    always_comb
    begin
        count_next = count_reg;
        done_next  = 1'b0;
        if (!cond_i)
        begin
            count_next = '0;
        end
        else if (count_reg >= limit_i)
        begin
            done_next = 1'b1;
        end
        else
        begin
            count_next = count_reg + 1'b1;
            done_next  = (count_reg + 1'b1) >= limit_i;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            count_reg <= '0;
            done_o    <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            done_o    <= done_next;
        end
    end
endmodule : hold_timer
`default_nettype wire

// File: slope_watch.sv
`timescale 1ns/10ps
`default_nettype none
// samples the sense word and restarts a timer on every slope; expiry flags line removal
module slope_watch
    import line_supervisor_pkg::*;
#(
    parameter int WIDTH = SENSE_W,
    parameter int LIMIT = REMOVAL_CYC
)
(
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] sample_i,
    output logic                  removed_o
);
    logic [WIDTH-1:0]   last_reg;
    logic [WIDTH-1:0]   last_next;
    logic [TIMER_W-1:0] count_reg;
    logic [TIMER_W-1:0] count_next;
    logic               removed_next;

    always_comb
    begin
        last_next    = sample_i;
        count_next   = count_reg;
        removed_next = removed_o;
        if (sample_i != last_reg)
        begin
            count_next   = '0;
            removed_next = 1'b0;
        end
        else if (count_reg >= TIMER_W'(LIMIT - 1))
        begin
            removed_next = 1'b1;
        end
        else
        begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            last_reg  <= '0;
            count_reg <= '0;
            removed_o <= 1'b0;
        end
        else
        begin
            last_reg  <= last_next;
            count_reg <= count_next;
            removed_o <= removed_next;
        end
    end
endmodule : slope_watch
`default_nettype wire

// File: line_input_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - input below stop threshold for the sag blanking time flags a line sag.
// - a line sag starts a soft-stop ramping the control level to zero only if sag blanking is shorter than under-voltage blanking.
// - continuous conduction is inhibited while a sag is active.
// - line return after a sag pulses recovery, clearing the bulk restart timer.
// - recovery aborts any soft-stop ramp and forces the control level to zero.
// - run only when input above start threshold and supply at turn-on level.
// - blanking timer starts below stop threshold; expiry while low is a fault.
// - an under-voltage fault stops switching and drops downstream enable.
// - after the fault, restart at once if supply is up, else charge first.
// - high line is chosen once input stays above 236 V for 300 us.
// - low line returns after input stays below 222 V for 25 ms.
// - after each fall to low line, high line is locked out for 500 ms.
// - high line divides bandwidth and gain by 4 and halves the foldback level.
// - line removal detection runs in every state, including fault and idle.
// - sampled input slopes restart a removal timer; expiry means line removed.
// - removal enables the discharge sink, stops gate drive, drops downstream enable.
// - the discharge sink stays on until input is below discharge end threshold.
// - if line returns in discharge, keep sinking to the end threshold, then restart.
// - after a bulk soft-stop, wait the 515 ms restart delay unless recovery bypasses.
module line_input_supervisor
    import line_supervisor_pkg::*;
#(
    parameter int SAG_BLANK       = SAG_BLANK_CYC,
    parameter int UNDERVOLT_BLANK = UNDERVOLT_BLANK_CYC,
    parameter int LINE_FILTER     = LINE_FILTER_CYC,
    parameter int LOW_LINE_TIME   = LOW_LINE_CYC,
    parameter int LOCKOUT_TIME    = LOCKOUT_CYC,
    parameter int REMOVAL_TIME    = REMOVAL_CYC,
    parameter int RESTART_DELAY   = RESTART_DELAY_CYC
)
(
    input  wire logic                                   clock_i,
    input  wire logic                                   reset_n_i,
    input  wire logic                                   above_undervolt_stop_threshold_i,
    input  wire logic                                   above_undervolt_start_threshold_i,
    input  wire logic                                   above_high_line_threshold_i,
    input  wire logic                                   above_low_line_threshold_i,
    input  wire logic                                   above_discharge_end_threshold_i,
    input  wire logic                                   supply_turn_on_level_i,
    input  wire logic                                   bulk_undervoltage_fault_i,
    input  wire logic                                   switching_request_i,
    input  wire logic [line_supervisor_pkg::SENSE_W-1:0] mains_sense_sample_i,
    input  wire logic [line_supervisor_pkg::CONTROL_W-1:0] control_demand_i,
    output logic [line_supervisor_pkg::CONTROL_W-1:0]   control_level_o,
    output logic                                        soft_stop_o,
    output logic                                        continuous_conduction_inhibit_o,
    output logic                                        line_recovery_o,
    output logic                                        startup_source_on_o,
    output logic                                        gate_drive_out_o,
    output logic                                        discharge_sink_current_o,
    output logic                                        downstream_enable_out_o,
    output logic                                        high_line_o,
    output logic [1:0]                                  bandwidth_shift_o,
    output logic [line_supervisor_pkg::CONTROL_W-1:0]   foldback_level_o,
    output logic                                        undervolt_fault_o,
    output logic                                        line_removed_o
);
    import line_supervisor_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // timers
    logic sag_done;
    logic blank_done;
    logic high_done;
    logic low_done;
    logic lock_run;
    logic lock_done;
    logic restart_run;
    logic restart_done;
    logic removed;

    hold_timer #(.WIDTH(TIMER_W)) sag_timer
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .cond_i(!above_undervolt_stop_threshold_i),
        .limit_i(TIMER_W'(SAG_BLANK)), .done_o(sag_done)
    );
    hold_timer #(.WIDTH(TIMER_W)) blank_timer
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .cond_i(!above_undervolt_stop_threshold_i),
        .limit_i(TIMER_W'(UNDERVOLT_BLANK)), .done_o(blank_done)
    );
    hold_timer #(.WIDTH(TIMER_W)) high_filter
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .cond_i(above_high_line_threshold_i),
        .limit_i(TIMER_W'(LINE_FILTER)), .done_o(high_done)
    );
    hold_timer #(.WIDTH(TIMER_W)) low_filter
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .cond_i(!above_low_line_threshold_i && high_line_o),
        .limit_i(TIMER_W'(LOW_LINE_TIME)), .done_o(low_done)
    );
    hold_timer #(.WIDTH(TIMER_W)) lockout_timer
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .cond_i(lock_run),
        .limit_i(TIMER_W'(LOCKOUT_TIME)), .done_o(lock_done)
    );
    hold_timer #(.WIDTH(TIMER_W)) restart_timer
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .cond_i(restart_run),
        .limit_i(TIMER_W'(RESTART_DELAY)), .done_o(restart_done)
    );
    slope_watch #(.WIDTH(SENSE_W), .LIMIT(REMOVAL_TIME)) removal_watch
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .sample_i(mains_sense_sample_i), .removed_o(removed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // line range selection
    logic lock_reg;
    logic lock_next;
    logic high_next;

    assign lock_run = lock_reg;

    always_comb
    begin
        high_next = high_line_o;
        lock_next = lock_reg;
        if (lock_reg && lock_done)
        begin
            lock_next = 1'b0;
        end
        if (high_line_o && low_done)
        begin
            high_next = 1'b0;
            lock_next = 1'b1;
        end
        else if (!high_line_o && high_done && !lock_reg)
        begin
            high_next = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            high_line_o       <= 1'b0;
            lock_reg          <= 1'b0;
            bandwidth_shift_o <= BANDWIDTH_SHIFT_LOW;
            foldback_level_o  <= FOLDBACK_LEVEL;
        end
        else
        begin
            high_line_o       <= high_next;
            lock_reg          <= lock_next;
            bandwidth_shift_o <= high_next ? BANDWIDTH_SHIFT_HIGH : BANDWIDTH_SHIFT_LOW;
            foldback_level_o  <= high_next ? (FOLDBACK_LEVEL >> 1) : FOLDBACK_LEVEL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run state machine
    run_state_t               state_reg;
    run_state_t               state_next;
    logic                     sag_reg;
    logic                     sag_next;
    logic                     recovery_next;
    logic [CONTROL_W-1:0]     level_next;
    logic                     bulk_stop_reg;
    logic                     bulk_stop_next;

    assign restart_run = (state_reg == ST_RESTART_WAIT);

    always_comb
    begin
        state_next     = state_reg;
        sag_next       = sag_reg;
        recovery_next  = 1'b0;
        level_next     = control_level_o;
        bulk_stop_next = bulk_stop_reg;
        if (sag_done)
        begin
            sag_next = 1'b1;
        end
        else if (sag_reg && above_undervolt_start_threshold_i)
        begin
            sag_next      = 1'b0;
            recovery_next = 1'b1;
        end
        case (state_reg)
            ST_WAIT_SUPPLY:
            begin
                level_next = CONTROL_ZERO;
                if (above_undervolt_start_threshold_i && supply_turn_on_level_i)
                begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
                level_next = control_demand_i;
                if (sag_done || bulk_undervoltage_fault_i)
                begin
                    state_next     = ST_SOFT_STOP;
                    bulk_stop_next = bulk_undervoltage_fault_i;
                end
            end
            ST_SOFT_STOP:
            begin
                if (control_level_o > CONTROL_STEP)
                begin
                    level_next = control_level_o - CONTROL_STEP;
                end
                else
                begin
                    level_next = CONTROL_ZERO;
                    state_next = bulk_stop_reg ? ST_RESTART_WAIT : ST_FAULT;
                end
                if (bulk_undervoltage_fault_i)
                begin
                    bulk_stop_next = 1'b1;
                end
                if (recovery_next)
                begin
                    level_next     = CONTROL_ZERO;
                    state_next     = ST_WAIT_SUPPLY;
                    bulk_stop_next = 1'b0;
                end
            end
            ST_RESTART_WAIT:
            begin
                level_next = CONTROL_ZERO;
                if (restart_done || recovery_next)
                begin
                    state_next     = ST_WAIT_SUPPLY;
                    bulk_stop_next = 1'b0;
                end
            end
            ST_FAULT:
            begin
                level_next = CONTROL_ZERO;
                if (above_undervolt_start_threshold_i)
                begin
                    state_next = ST_WAIT_SUPPLY;
                end
            end
            ST_DISCHARGE:
            begin
                level_next = CONTROL_ZERO;
                if (!above_discharge_end_threshold_i)
                begin
                    state_next = ST_WAIT_SUPPLY;
                end
            end
            default:
            begin
                state_next = ST_WAIT_SUPPLY;
            end
        endcase
        if (blank_done && state_reg != ST_DISCHARGE && state_reg != ST_FAULT)
        begin
            state_next = ST_FAULT;
            level_next = CONTROL_ZERO;
        end
        // act on the onset only, so a line that stays removed does not re-arm a finished discharge
        if (removed && !line_removed_o)
        begin
            state_next = ST_DISCHARGE;
            level_next = CONTROL_ZERO;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            state_reg                       <= ST_WAIT_SUPPLY;
            sag_reg                         <= 1'b0;
            bulk_stop_reg                   <= 1'b0;
            control_level_o                 <= CONTROL_ZERO;
            soft_stop_o                     <= 1'b0;
            continuous_conduction_inhibit_o <= 1'b0;
            line_recovery_o                 <= 1'b0;
            startup_source_on_o             <= 1'b0;
            gate_drive_out_o                <= 1'b0;
            discharge_sink_current_o        <= 1'b0;
            downstream_enable_out_o         <= 1'b0;
            undervolt_fault_o               <= 1'b0;
            line_removed_o                  <= 1'b0;
        end
        else
        begin
            state_reg                       <= state_next;
            sag_reg                         <= sag_next;
            bulk_stop_reg                   <= bulk_stop_next;
            control_level_o                 <= level_next;
            soft_stop_o                     <= (state_next == ST_SOFT_STOP);
            continuous_conduction_inhibit_o <= sag_next;
            line_recovery_o                 <= recovery_next;
            startup_source_on_o             <= (state_next == ST_WAIT_SUPPLY) && !supply_turn_on_level_i;
            gate_drive_out_o                <= ((state_next == ST_RUN) || (state_next == ST_SOFT_STOP))
                                               && switching_request_i;
            discharge_sink_current_o        <= (state_next == ST_DISCHARGE);
            downstream_enable_out_o         <= (state_next == ST_RUN) && !bulk_undervoltage_fault_i;
            undervolt_fault_o               <= (state_next == ST_FAULT);
            line_removed_o                  <= removed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_sink_follows_removal: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(removed) |=> discharge_sink_current_o && !gate_drive_out_o && !downstream_enable_out_o)
        else $error("sink not on after line removal");
    a_sink_ends_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        discharge_sink_current_o && !above_discharge_end_threshold_i && !removed |=> !discharge_sink_current_o)
        else $error("sink stayed on below end threshold");
    a_fault_drops_enable: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        undervolt_fault_o |-> !downstream_enable_out_o && !gate_drive_out_o)
        else $error("enable high during fault");
    a_run_needs_inputs: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $past(state_reg) == ST_WAIT_SUPPLY && state_reg == ST_RUN |->
        $past(above_undervolt_start_threshold_i) && $past(supply_turn_on_level_i))
        else $error("run entered without start conditions");
    a_recovery_zeroes: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        line_recovery_o && $past(state_reg) == ST_SOFT_STOP |-> control_level_o == CONTROL_ZERO)
        else $error("control level not zero on recovery");
    a_inhibit_on_sag: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        sag_done |=> continuous_conduction_inhibit_o)
        else $error("conduction not inhibited in sag");
    a_lockout_blocks: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $fell(high_line_o) || lock_reg |-> lock_reg && !high_line_o)
        else $error("high line reselected during lockout");
    a_high_line_scaling: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        high_line_o |-> bandwidth_shift_o == BANDWIDTH_SHIFT_HIGH && foldback_level_o == (FOLDBACK_LEVEL >> 1))
        else $error("high line scaling wrong");
    a_recovery_pulse: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        line_recovery_o |=> !line_recovery_o)
        else $error("recovery not a single pulse");
endmodule : line_input_supervisor
`default_nettype wire

// File: downstream_converter_model.sv
`timescale 1ns/10ps
`default_nettype none
module downstream_converter_model
(
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic enable_i,
    input  wire logic aux_supply_i,
    output logic      supply_ok_o
);
    // the downstream stage keeps the controller supply up while it is enabled or while the aux supply is present
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
            supply_ok_o <= 1'b0;
        else
            supply_ok_o <= enable_i | aux_supply_i;
    end
endmodule : downstream_converter_model
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import line_supervisor_pkg::*;
    localparam int SB = 8, UB = 20, LF = 6, LL = 10, LK = 40, RT = 30, RD = 20;
    logic clock_i = 1'b0, reset_n_i = 1'b0, stop_ok = 1'b1, start_ok = 1'b1, hi_ok = 1'b0, lo_ok = 1'b1;
    logic dis_ok = 1'b1, bulk = 1'b0, sw_req = 1'b1, aux = 1'b1, slopes = 1'b1, supply;
    logic [SENSE_W-1:0] sample = 10'h000;
    logic [CONTROL_W-1:0] demand = 10'h155, level, fold, lv;
    logic [1:0] bw;
    logic inh, sstop, rec, src, gate, sink, dse, hl, flt, rem;
    int num_errors = 0, checks = 0, cycles = 0;
    always #25 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////////////
    line_input_supervisor #(.SAG_BLANK(SB), .UNDERVOLT_BLANK(UB), .LINE_FILTER(LF), .LOW_LINE_TIME(LL),
        .LOCKOUT_TIME(LK), .REMOVAL_TIME(RT), .RESTART_DELAY(RD)) line_input_supervisor_i
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i),
        .above_undervolt_stop_threshold_i(stop_ok), .above_undervolt_start_threshold_i(start_ok),
        .above_high_line_threshold_i(hi_ok), .above_low_line_threshold_i(lo_ok),
        .above_discharge_end_threshold_i(dis_ok), .supply_turn_on_level_i(supply),
        .bulk_undervoltage_fault_i(bulk), .switching_request_i(sw_req),
        .mains_sense_sample_i(sample), .control_demand_i(demand), .control_level_o(level),
        .soft_stop_o(sstop), .continuous_conduction_inhibit_o(inh), .line_recovery_o(rec),
        .startup_source_on_o(src), .gate_drive_out_o(gate), .discharge_sink_current_o(sink),
        .downstream_enable_out_o(dse), .high_line_o(hl), .bandwidth_shift_o(bw),
        .foldback_level_o(fold), .undervolt_fault_o(flt), .line_removed_o(rem)
    );
    downstream_converter_model downstream_converter_model_i
    (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(dse), .aux_supply_i(aux), .supply_ok_o(supply)
    );
    ////////////////////////////////////////////////////////////////////////
    // any change of the sample word counts as a slope of the mains
    always @(posedge clock_i)
    begin
        #2;
        if (slopes) sample = sample + 10'h001;
    end
    always @(posedge clock_i)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask : tick
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic pick(input int sel);
        logic [9:0] v;
        v = {inh, sstop, rec, src, gate, sink, dse, hl, flt, rem};
        return v[9-sel];
    endfunction : pick
    // output sel must not reach val in lo cycles, then must reach it within hi more
    task automatic expect_within(input int sel, input logic val, input int lo, input int hi);
        int early;
        int n;
        early = 0;
        n = 0;
        repeat (lo)
        begin
            tick(1);
            if (pick(sel) === val) early = 1;
        end
        while (pick(sel) !== val && n < hi)
        begin
            tick(1);
            n = n + 1;
        end
        check({9'h0, early[0]}, 10'h000);
        check({9'h0, pick(sel)}, {9'h0, val});
    endtask : expect_within
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(16);
        check(level, CONTROL_ZERO);
        check({5'h0, flt, dse, gate, sink, hl}, 10'h000);
        check(fold, FOLDBACK_LEVEL);
        reset_n_i = 1'b1;
        expect_within(6, 1'b1, 0, 8);
        tick(2);
        check(level, demand);
        check({9'h0, gate}, 10'h001);
        sw_req = 1'b0;
        tick(2);
        check({9'h0, gate}, 10'h000);
        sw_req = 1'b1;
        $display("startup test done");
        stop_ok = 1'b0;
        start_ok = 1'b0;
        expect_within(0, 1'b1, SB - 1, 4);
        check({9'h0, sstop}, 10'h001);
        lv = level;
        tick(1);
        check(level, lv - 10'h001);
        stop_ok = 1'b1;
        start_ok = 1'b1;
        expect_within(2, 1'b1, 0, 4);
        check(level, CONTROL_ZERO);
        tick(1);
        check({9'h0, rec}, 10'h000);
        expect_within(6, 1'b1, 0, 8);
        $display("sag test done");
        stop_ok = 1'b0;
        start_ok = 1'b0;
        aux = 1'b0;
        expect_within(8, 1'b1, UB - 1, 6);
        check({8'h0, dse, gate}, 10'h000);
        stop_ok = 1'b1;
        start_ok = 1'b1;
        expect_within(3, 1'b1, 0, 4);
        check({9'h0, dse}, 10'h000);
        aux = 1'b1;
        expect_within(6, 1'b1, 0, 8);
        $display("brown-out test done");
        hi_ok = 1'b1;
        expect_within(7, 1'b1, LF - 1, 5);
        check({8'h0, bw}, 10'h002);
        check(fold, FOLDBACK_LEVEL >> 1);
        hi_ok = 1'b0;
        lo_ok = 1'b0;
        expect_within(7, 1'b0, LL - 1, 5);
        check(fold, FOLDBACK_LEVEL);
        lo_ok = 1'b1;
        hi_ok = 1'b1;
        expect_within(7, 1'b1, LK - 3, LF + 8);
        $display("line range test done");
        slopes = 1'b0;
        expect_within(5, 1'b1, RT - 2, 6);
        tick(1);
        check({7'h0, dse, gate, rem}, 10'h001);
        slopes = 1'b1;
        tick(8);
        check({9'h0, sink}, 10'h001);
        dis_ok = 1'b0;
        expect_within(5, 1'b0, 0, 3);
        dis_ok = 1'b1;
        expect_within(6, 1'b1, 0, 10);
        $display("removal test done");
        demand = 10'h010;
        tick(3);
        bulk = 1'b1;
        expect_within(6, 1'b0, 0, 3);
        tick(2);
        bulk = 1'b0;
        expect_within(6, 1'b1, RD + 8, 30);
        $display("bulk restart test done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
